/* pkg/pnp_regs_pkg.sv */
package pnp_regs_pkg;

  // ------------------------------------------------------------
  // Auto-configuration ports
  // ------------------------------------------------------------
  localparam logic [15:0] PORT_INDEX = 16'h0279;
  localparam logic [15:0] PORT_WDATA = 16'h0A79;
  localparam logic [1:0] RPORT_LOW_BITS = 2'h3;
  localparam int IO_RANGE_BITS = 5;

  // ------------------------------------------------------------
  // Register indices
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_READ_PORT_LOCATOR = 8'h00;
  localparam logic [7:0] IDX_ISOLATION_BIT_COMPARE = 8'h01;
  localparam logic [7:0] IDX_CARD_COMMAND_CONTROL = 8'h02;
  localparam logic [7:0] IDX_WAKE_BY_NUMBER = 8'h03;
  localparam logic [7:0] IDX_RESOURCE_BYTE_READ = 8'h04;
  localparam logic [7:0] IDX_RESOURCE_READY_STATUS = 8'h05;
  localparam logic [7:0] IDX_CARD_SELECT_VALUE = 8'h06;
  localparam logic [7:0] IDX_LOGICAL_UNIT_NUMBER = 8'h07;
  localparam logic [7:0] IDX_UNIT_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_IO_CONFLICT_CHECK = 8'h31;
  localparam logic [7:0] IDX_ROM_BASE_HIGH = 8'h40;
  localparam logic [7:0] IDX_ROM_BASE_LOW = 8'h41;
  localparam logic [7:0] IDX_ROM_WIDTH_CONTROL = 8'h42;
  localparam logic [7:0] IDX_SAVED_SELECT_COPY = 8'hF5;

  // ------------------------------------------------------------
  // Field positions, masks and fixed values
  // ------------------------------------------------------------
  localparam int CMD_RESET_BIT = 0;
  localparam int CMD_WAIT_KEY_BIT = 1;
  localparam int CMD_CLEAR_CSN_BIT = 2;
  localparam int ACTIVATE_BIT = 0;
  localparam int CHECK_ENABLE_BIT = 1;
  localparam int CHECK_PATTERN_BIT = 0;
  localparam logic [7:0] ROM_HIGH_WR_MASK = 8'h0D;
  localparam logic [7:0] ROM_LOW_WR_MASK = 8'hC0;
  localparam logic [7:0] CHECK_PATTERN_SET = 8'h55;
  localparam logic [7:0] CHECK_PATTERN_CLEAR = 8'hAA;
  localparam logic [7:0] LOGICAL_UNIT_VALUE = 8'h00;
  localparam logic [7:0] ROM_WIDTH_VALUE = 8'h00;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_READ_PORT = 8'h00;
  localparam logic [7:0] RST_CSN = 8'h00;
  localparam logic [7:0] RST_ROM_HIGH = 8'h00;
  localparam logic [7:0] RST_ROM_LOW = 8'h00;
  localparam logic [1:0] RST_CHECK = 2'h0;

  // ------------------------------------------------------------
  // Resource store and timing
  // ------------------------------------------------------------
  localparam int RES_ADDR_W = 6;
  localparam int RES_DEPTH = 64;
  localparam logic [1:0] RES_LATENCY = 2'h2;
  localparam int ROM_SIZE_W = 3;

  // ------------------------------------------------------------
  // Card states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_WAIT_KEY = 4'b0001,
    ST_SLEEP = 4'b0010,
    ST_ISOLATION = 4'b0100,
    ST_CONFIG = 4'b1000
  } card_state_type;

endpackage : pnp_regs_pkg

/* rtl/port_decode.sv */
`timescale 1ns/1ps
module port_decode (
  // ISA address
  input wire logic [15:0] isa_addr,
  // Decode setup
  input wire logic [7:0] read_port_sel,
  input wire logic [15:0] io_base,
  // Hits
  output logic hit_index,
  output logic hit_wdata,
  output logic hit_rdata,
  output logic hit_range
);

  function automatic logic same_port(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction : same_port

  always_comb begin
    hit_index = same_port(isa_addr, pnp_regs_pkg::PORT_INDEX);
    hit_wdata = same_port(isa_addr, pnp_regs_pkg::PORT_WDATA);
    hit_rdata = same_port(isa_addr, {6'h00, read_port_sel, pnp_regs_pkg::RPORT_LOW_BITS});
    hit_range = isa_addr[15:pnp_regs_pkg::IO_RANGE_BITS] == io_base[15:pnp_regs_pkg::IO_RANGE_BITS];
  end

endmodule : port_decode

/* rtl/resource_store.sv */
`timescale 1ns/1ps
module resource_store (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Load port
  input wire logic load_en,
  input wire logic [pnp_regs_pkg::RES_ADDR_W-1:0] load_addr,
  input wire logic [7:0] load_data,
  // Read port
  input wire logic [pnp_regs_pkg::RES_ADDR_W-1:0] rd_addr,
  output logic [7:0] rd_data_q
);

  logic [7:0] mem [pnp_regs_pkg::RES_DEPTH];

  always_ff @(posedge clk_sys) begin
    if (load_en) begin
      mem[load_addr] <= load_data;
    end
  end

  // Read data is registered so the status flag can wait on it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule : resource_store

/* rtl/pnp_card_regs.sv */
`timescale 1ns/1ps
module pnp_card_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // ISA I/O cycle, one strobe per access
  input wire logic [15:0] isa_addr,
  input wire logic isa_wr,
  input wire logic isa_rd,
  input wire logic [7:0] isa_wdata,
  output logic [7:0] isa_rdata_q,
  output logic isa_rdata_oe_q,
  // Surrounding card logic
  input wire logic key_seen,
  input wire logic iso_bit_data,
  input wire logic [15:0] io_base,
  input wire logic [pnp_regs_pkg::ROM_SIZE_W-1:0] rom_size_cfg,
  input wire logic res_load_en,
  input wire logic [pnp_regs_pkg::RES_ADDR_W-1:0] res_load_addr,
  input wire logic [7:0] res_load_data,
  // Card status
  output pnp_regs_pkg::card_state_type card_state_q,
  output logic iso_compare_q,
  output logic [7:0] card_select_value_q,
  output logic [7:0] saved_select_copy_q,
  output logic [7:0] read_port_sel_q,
  output logic unit_active_q,
  output logic range_check_on_q,
  output logic [15:0] boot_rom_base_q,
  output logic [pnp_regs_pkg::ROM_SIZE_W-1:0] boot_rom_size_q,
  output logic device_reset_q
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    pnp_regs_pkg::card_state_type st;
    logic [7:0] index;
    logic [7:0] rport;
    logic [7:0] card_select_value;
    logic [7:0] csn_sav;
    logic active;
    logic [1:0] check;
    logic [7:0] rom_hi;
    logic [7:0] rom_lo;
    logic [7:0] rdata;
    logic rdata_oe;
    logic iso_pulse;
    logic dev_reset;
    logic [pnp_regs_pkg::RES_ADDR_W-1:0] res_ptr;
    logic [1:0] res_wait;
    logic [pnp_regs_pkg::ROM_SIZE_W-1:0] rom_size;
  } regs_type;

  regs_type s_q;
  regs_type s_d;

  logic hit_index;
  logic hit_wdata;
  logic hit_rdata;
  logic hit_range;
  logic [7:0] res_byte;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  port_decode u_decode (
    .isa_addr(isa_addr),
    .read_port_sel(s_q.rport),
    .io_base(io_base),
    .hit_index(hit_index),
    .hit_wdata(hit_wdata),
    .hit_rdata(hit_rdata),
    .hit_range(hit_range)
  );

  resource_store u_res (
    .clk_sys(clk_sys),
    .rst(rst),
    .load_en(res_load_en),
    .load_addr(res_load_addr),
    .load_data(res_load_data),
    .rd_addr(s_q.res_ptr),
    .rd_data_q(res_byte)
  );

  function automatic logic is_on(input pnp_regs_pkg::card_state_type st);
    return (st == pnp_regs_pkg::ST_ISOLATION) || (st == pnp_regs_pkg::ST_CONFIG);
  endfunction : is_on

  function automatic logic check_live(input logic [1:0] check, input logic active);
    // Range check only means something while the device is off the bus
    return check[pnp_regs_pkg::CHECK_ENABLE_BIT] && !active;
  endfunction : check_live

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rdata_oe = 1'b0;
    s_d.iso_pulse = 1'b0;
    s_d.dev_reset = 1'b0;
    s_d.rom_size = rom_size_cfg;
    if (s_q.res_wait != 2'h0) begin
      s_d.res_wait = s_q.res_wait - 2'h1;
    end

    if (key_seen && s_q.st == pnp_regs_pkg::ST_WAIT_KEY) begin
      s_d.st = pnp_regs_pkg::ST_SLEEP;
    end

    // Index is latched once, data accesses reuse it
    if (isa_wr && hit_index) begin
      s_d.index = isa_wdata;
    end

    // Data port writes
    if (isa_wr && hit_wdata && s_q.st != pnp_regs_pkg::ST_WAIT_KEY) begin
      unique case (s_q.index)
        pnp_regs_pkg::IDX_WAKE_BY_NUMBER: begin
          if (isa_wdata == s_q.card_select_value) begin
            s_d.st = (isa_wdata == 8'h00) ? pnp_regs_pkg::ST_ISOLATION
                                          : pnp_regs_pkg::ST_CONFIG;
            s_d.res_ptr = '0;
            s_d.res_wait = pnp_regs_pkg::RES_LATENCY;
          end else if (s_q.st != pnp_regs_pkg::ST_SLEEP) begin
            s_d.st = pnp_regs_pkg::ST_SLEEP;
          end
        end
        pnp_regs_pkg::IDX_CARD_COMMAND_CONTROL: begin
          // Bits act once and are never stored, so they read back clear
          if (isa_wdata[pnp_regs_pkg::CMD_RESET_BIT]) begin
            s_d.dev_reset = 1'b1;
            s_d.active = 1'b0;
            s_d.check = pnp_regs_pkg::RST_CHECK;
            s_d.rom_hi = pnp_regs_pkg::RST_ROM_HIGH;
            s_d.rom_lo = pnp_regs_pkg::RST_ROM_LOW;
          end
          if (isa_wdata[pnp_regs_pkg::CMD_WAIT_KEY_BIT]) begin
            s_d.st = pnp_regs_pkg::ST_WAIT_KEY;
          end
          if (isa_wdata[pnp_regs_pkg::CMD_CLEAR_CSN_BIT]) begin
            s_d.card_select_value = pnp_regs_pkg::RST_CSN;
            s_d.csn_sav = pnp_regs_pkg::RST_CSN;
          end
        end
        pnp_regs_pkg::IDX_READ_PORT_LOCATOR: begin
          if (is_on(s_q.st)) begin
            s_d.rport = isa_wdata;
          end
        end
        pnp_regs_pkg::IDX_CARD_SELECT_VALUE: begin
          if (is_on(s_q.st)) begin
            s_d.card_select_value = isa_wdata;
            s_d.csn_sav = isa_wdata;
            s_d.st = pnp_regs_pkg::ST_CONFIG;
          end
        end
        pnp_regs_pkg::IDX_UNIT_ACTIVATE: begin
          if (s_q.st == pnp_regs_pkg::ST_CONFIG) begin
            s_d.active = isa_wdata[pnp_regs_pkg::ACTIVATE_BIT];
          end
        end
        pnp_regs_pkg::IDX_IO_CONFLICT_CHECK: begin
          if (s_q.st == pnp_regs_pkg::ST_CONFIG) begin
            s_d.check = isa_wdata[1:0];
          end
        end
        pnp_regs_pkg::IDX_ROM_BASE_HIGH: begin
          if (s_q.st == pnp_regs_pkg::ST_CONFIG) begin
            s_d.rom_hi = isa_wdata & pnp_regs_pkg::ROM_HIGH_WR_MASK;
          end
        end
        pnp_regs_pkg::IDX_ROM_BASE_LOW: begin
          if (s_q.st == pnp_regs_pkg::ST_CONFIG) begin
            s_d.rom_lo = isa_wdata & pnp_regs_pkg::ROM_LOW_WR_MASK;
          end
        end
        default: begin
          // Read-only or undefined index: nothing changes
          s_d.index = s_q.index;
        end
      endcase
    end

    // Data port reads
    if (isa_rd && hit_rdata && is_on(s_q.st)) begin
      s_d.rdata_oe = 1'b1;
      s_d.rdata = 8'h00;
      unique case (s_q.index)
        pnp_regs_pkg::IDX_ISOLATION_BIT_COMPARE: begin
          if (s_q.st == pnp_regs_pkg::ST_ISOLATION) begin
            s_d.iso_pulse = 1'b1;
            s_d.rdata = {7'h00, iso_bit_data};
          end
        end
        pnp_regs_pkg::IDX_RESOURCE_BYTE_READ: begin
          // A read before the flag is up does not advance the pointer and returns the old byte only while res_wait is 2; host must poll
          s_d.rdata = res_byte;
          if (s_q.res_wait == 2'h0) begin
            s_d.res_ptr = s_q.res_ptr + 1'b1;
            s_d.res_wait = pnp_regs_pkg::RES_LATENCY;
          end
        end
        pnp_regs_pkg::IDX_RESOURCE_READY_STATUS: begin
          s_d.rdata = {7'h00, s_q.res_wait == 2'h0};
        end
        pnp_regs_pkg::IDX_CARD_SELECT_VALUE: begin
          s_d.rdata = s_q.card_select_value;
        end
        pnp_regs_pkg::IDX_SAVED_SELECT_COPY: begin
          s_d.rdata = s_q.csn_sav;
        end
        pnp_regs_pkg::IDX_LOGICAL_UNIT_NUMBER: begin
          s_d.rdata = pnp_regs_pkg::LOGICAL_UNIT_VALUE;
        end
        pnp_regs_pkg::IDX_UNIT_ACTIVATE: begin
          s_d.rdata = {7'h00, s_q.active};
        end
        pnp_regs_pkg::IDX_IO_CONFLICT_CHECK: begin
          s_d.rdata = {6'h00, s_q.check};
        end
        pnp_regs_pkg::IDX_ROM_BASE_HIGH: begin
          s_d.rdata = s_q.rom_hi;
        end
        pnp_regs_pkg::IDX_ROM_BASE_LOW: begin
          s_d.rdata = s_q.rom_lo;
        end
        pnp_regs_pkg::IDX_ROM_WIDTH_CONTROL: begin
          s_d.rdata = pnp_regs_pkg::ROM_WIDTH_VALUE;
        end
        default: begin
          // Write-only and undefined indices
          s_d.rdata = 8'h00;
        end
      endcase
    end else if (isa_rd && hit_range && check_live(s_q.check, s_q.active)) begin
      s_d.rdata_oe = 1'b1;
      s_d.rdata = s_q.check[pnp_regs_pkg::CHECK_PATTERN_BIT] ?
                  pnp_regs_pkg::CHECK_PATTERN_SET : pnp_regs_pkg::CHECK_PATTERN_CLEAR;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q.st <= pnp_regs_pkg::ST_WAIT_KEY;
      s_q.index <= 8'h00;
      s_q.rport <= pnp_regs_pkg::RST_READ_PORT;
      s_q.card_select_value <= pnp_regs_pkg::RST_CSN;
      s_q.csn_sav <= pnp_regs_pkg::RST_CSN;
      s_q.active <= 1'b0;
      s_q.check <= pnp_regs_pkg::RST_CHECK;
      s_q.rom_hi <= pnp_regs_pkg::RST_ROM_HIGH;
      s_q.rom_lo <= pnp_regs_pkg::RST_ROM_LOW;
      s_q.rdata <= 8'h00;
      s_q.rdata_oe <= 1'b0;
      s_q.iso_pulse <= 1'b0;
      s_q.dev_reset <= 1'b0;
      s_q.res_ptr <= '0;
      s_q.res_wait <= pnp_regs_pkg::RES_LATENCY;
      s_q.rom_size <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign isa_rdata_q = s_q.rdata;
  assign isa_rdata_oe_q = s_q.rdata_oe;
  assign card_state_q = s_q.st;
  assign iso_compare_q = s_q.iso_pulse;
  assign card_select_value_q = s_q.card_select_value;
  assign saved_select_copy_q = s_q.csn_sav;
  assign read_port_sel_q = s_q.rport;
  assign unit_active_q = s_q.active;
  assign range_check_on_q = s_q.check[pnp_regs_pkg::CHECK_ENABLE_BIT];
  assign boot_rom_base_q = {s_q.rom_hi, s_q.rom_lo};
  assign boot_rom_size_q = s_q.rom_size;
  assign device_reset_q = s_q.dev_reset;

endmodule : pnp_card_regs

/* test/pnp_card_regs_monitor.sv */
`timescale 1ns/1ps
module pnp_card_regs_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // ISA cycle
  input wire logic [15:0] isa_addr,
  input wire logic isa_wr,
  input wire logic isa_rd,
  input wire logic [7:0] isa_wdata,
  input wire logic [7:0] isa_rdata_q,
  input wire logic isa_rdata_oe_q,
  // Card side
  input wire logic iso_bit_data,
  input wire logic [15:0] io_base,
  input wire logic [pnp_regs_pkg::ROM_SIZE_W-1:0] rom_size_cfg,
  input wire pnp_regs_pkg::card_state_type card_state_q,
  input wire logic iso_compare_q,
  input wire logic [7:0] card_select_value_q,
  input wire logic [7:0] saved_select_copy_q,
  input wire logic [7:0] read_port_sel_q,
  input wire logic unit_active_q,
  input wire logic range_check_on_q,
  input wire logic [pnp_regs_pkg::ROM_SIZE_W-1:0] boot_rom_size_q,
  input wire logic device_reset_q
);
  // ------------------------------------------------------------
  // Index shadow
  // ------------------------------------------------------------
  logic [7:0] idx_q;
  logic [7:0] idx_d;
  logic live;
  logic [15:0] rport;
  assign rport = {6'h00, read_port_sel_q, 2'h3};
  assign live = (card_state_q == pnp_regs_pkg::ST_ISOLATION) ||
    (card_state_q == pnp_regs_pkg::ST_CONFIG);
  always_comb begin
    idx_d = (isa_wr && isa_addr == pnp_regs_pkg::PORT_INDEX) ? isa_wdata : idx_q;
  end
  always_ff @(posedge clk_sys) begin
    idx_q <= rst ? 8'h00 : idx_d;
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence data_wr(logic [7:0] i);
    isa_wr && isa_addr == pnp_regs_pkg::PORT_WDATA && idx_q == i &&
      card_state_q != pnp_regs_pkg::ST_WAIT_KEY;
  endsequence
  sequence cmd_wr(int b);
    data_wr(pnp_regs_pkg::IDX_CARD_COMMAND_CONTROL) ##0 isa_wdata[b];
  endsequence
  a_read_answer: assert property (isa_rd && isa_addr == rport && live |=> isa_rdata_oe_q)
    else $error("read port gave no answer");
  a_port_move: assert property (data_wr(pnp_regs_pkg::IDX_READ_PORT_LOCATOR) ##0 live
    |=> read_port_sel_q == $past(isa_wdata)) else $error("read port not moved");
  a_iso_compare: assert property (isa_rd && isa_addr == rport && live &&
    idx_q == pnp_regs_pkg::IDX_ISOLATION_BIT_COMPARE && card_state_q[2]
    |=> iso_compare_q && isa_rdata_q == {7'h00, $past(iso_bit_data)})
    else $error("isolation compare missing");
  a_number_copy: assert property (data_wr(pnp_regs_pkg::IDX_CARD_SELECT_VALUE) ##0 live
    |=> card_select_value_q == $past(isa_wdata) && saved_select_copy_q == $past(isa_wdata))
    else $error("card number or copy wrong");
  a_number_clear: assert property (cmd_wr(2)
    |=> card_select_value_q == 8'h00 && saved_select_copy_q == 8'h00)
    else $error("card number not cleared");
  a_key_return: assert property (cmd_wr(1) ##0 !isa_wdata[2]
    |=> card_state_q == pnp_regs_pkg::ST_WAIT_KEY && $stable(card_select_value_q))
    else $error("wait for key command failed");
  a_reset_pulse: assert property (cmd_wr(0) ##0 !isa_wdata[2]
    |=> device_reset_q && !unit_active_q && $stable(card_select_value_q) ##1 !device_reset_q)
    else $error("reset command wrong");
  a_wake_target: assert property (data_wr(pnp_regs_pkg::IDX_WAKE_BY_NUMBER) ##0
    card_state_q == pnp_regs_pkg::ST_SLEEP && isa_wdata == card_select_value_q
    |=> card_state_q == ($past(isa_wdata) == 8'h00 ? pnp_regs_pkg::ST_ISOLATION :
    pnp_regs_pkg::ST_CONFIG)) else $error("wake went to wrong state");
  a_range_answer: assert property (isa_rd && isa_addr[15:5] == io_base[15:5] &&
    isa_addr != rport && range_check_on_q && !unit_active_q
    |=> isa_rdata_oe_q && isa_rdata_q inside {8'h55, 8'haa}) else $error("range answer wrong");
  a_rom_size: assert property (!$past(rst) |-> boot_rom_size_q == $past(rom_size_cfg))
    else $error("boot rom size wrong");
endmodule : pnp_card_regs_monitor

bind pnp_card_regs pnp_card_regs_monitor u_pnp_card_regs_monitor (
  .clk_sys(clk_sys), .rst(rst), .isa_addr(isa_addr), .isa_wr(isa_wr), .isa_rd(isa_rd),
  .isa_wdata(isa_wdata), .isa_rdata_q(isa_rdata_q), .isa_rdata_oe_q(isa_rdata_oe_q),
  .iso_bit_data(iso_bit_data), .io_base(io_base), .rom_size_cfg(rom_size_cfg),
  .card_state_q(card_state_q), .iso_compare_q(iso_compare_q),
  .card_select_value_q(card_select_value_q), .saved_select_copy_q(saved_select_copy_q),
  .read_port_sel_q(read_port_sel_q), .unit_active_q(unit_active_q),
  .range_check_on_q(range_check_on_q), .boot_rom_size_q(boot_rom_size_q),
  .device_reset_q(device_reset_q)
);

/* test/isa_host_model.sv */
`timescale 1ns/1ps
module isa_host_model (
  // Clock
  input wire logic clk_sys,
  // ISA cycle
  output logic [15:0] isa_addr,
  output logic isa_wr,
  output logic isa_rd,
  output logic [7:0] isa_wdata,
  input wire logic [7:0] isa_rdata_q,
  input wire logic isa_rdata_oe_q
);
  logic [15:0] rport = 16'h0003;
  initial begin
    isa_addr = 16'h0000;
    isa_wr = 1'b0;
    isa_rd = 1'b0;
    isa_wdata = 8'h00;
  end
  // Released lines show the inverse so stale values never pass for answers
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    isa_addr <= a;
    isa_wdata <= d;
    isa_wr <= 1'b1;
    @(posedge clk_sys);
    isa_wr <= 1'b0;
    isa_addr <= ~a;
    isa_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys);
    isa_addr <= a;
    isa_rd <= 1'b1;
    @(posedge clk_sys);
    isa_rd <= 1'b0;
    isa_addr <= ~a;
    #1;
    v = isa_rdata_oe_q;
    d = v ? isa_rdata_q : 8'hxx;
  endtask : rd
  task automatic reg_wr(input logic [7:0] i, input logic [7:0] d);
    wr(pnp_regs_pkg::PORT_INDEX, i);
    wr(pnp_regs_pkg::PORT_WDATA, d);
    if (i == 8'h00) begin
      rport = {6'h00, d, 2'h3};
    end
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] i, output logic [7:0] d);
    logic v;
    wr(pnp_regs_pkg::PORT_INDEX, i);
    rd(rport, d, v);
  endtask : reg_rd
  task automatic res_rd(output logic [7:0] d);
    logic [7:0] s;
    s = 8'h00;
    for (int n = 0; n < 20 && s[0] !== 1'b1; n++) reg_rd(8'h05, s);
    reg_rd(8'h04, d);
  endtask : res_rd
  task automatic activate();
    reg_wr(8'h31, 8'h00);
    reg_wr(8'h30, 8'h01);
  endtask : activate
endmodule : isa_host_model

/* test/isa_pnp_card_registers_bench.sv */
`timescale 1ns/1ps
module isa_pnp_card_registers_bench;
  logic clk_sys, rst, isa_wr, isa_rd, isa_rdata_oe_q, key_seen, iso_bit_data, res_load_en;
  logic [15:0] isa_addr, io_base, boot_rom_base_q;
  logic [7:0] isa_wdata, isa_rdata_q, res_load_data, csn_q, sav_q, rps_q, d, r, csn_m;
  logic [5:0] res_load_addr;
  logic [2:0] rom_size_cfg, rsz_q;
  logic iso_q, act_q, rng_q, drst_q, v;
  pnp_regs_pkg::card_state_type st_q;
  logic [7:0] res_m[$];
  logic [7:0] seed = 8'h54;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [7:0] tbl [8][3] = '{'{8'h07, 8'hff, 8'h00}, '{8'h42, 8'hff, 8'h00},
    '{8'h40, 8'hff, 8'h0d}, '{8'h41, 8'hff, 8'hc0}, '{8'h20, 8'hff, 8'h00},
    '{8'h02, 8'h00, 8'h00}, '{8'h30, 8'h00, 8'h00}, '{8'h31, 8'h03, 8'h03}};

  pnp_card_regs u_pnp_card_regs (.clk_sys(clk_sys), .rst(rst), .isa_addr(isa_addr),
    .isa_wr(isa_wr), .isa_rd(isa_rd), .isa_wdata(isa_wdata), .isa_rdata_q(isa_rdata_q),
    .isa_rdata_oe_q(isa_rdata_oe_q), .key_seen(key_seen), .iso_bit_data(iso_bit_data),
    .io_base(io_base), .rom_size_cfg(rom_size_cfg), .res_load_en(res_load_en),
    .res_load_addr(res_load_addr), .res_load_data(res_load_data), .card_state_q(st_q),
    .iso_compare_q(iso_q), .card_select_value_q(csn_q), .saved_select_copy_q(sav_q),
    .read_port_sel_q(rps_q), .unit_active_q(act_q), .range_check_on_q(rng_q),
    .boot_rom_base_q(boot_rom_base_q), .boot_rom_size_q(rsz_q), .device_reset_q(drst_q));
  isa_host_model u_isa_host_model (.clk_sys(clk_sys), .isa_addr(isa_addr), .isa_wr(isa_wr),
    .isa_rd(isa_rd), .isa_wdata(isa_wdata), .isa_rdata_q(isa_rdata_q),
    .isa_rdata_oe_q(isa_rdata_oe_q));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] lfsr();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction : lfsr
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_st(input pnp_regs_pkg::card_state_type got,
    input pnp_regs_pkg::card_state_type exp);
    chk({12'h000, got}, {12'h000, exp});
  endtask : chk_st
  task automatic key();
    @(posedge clk_sys);
    key_seen <= 1'b1;
    @(posedge clk_sys);
    key_seen <= 1'b0;
  endtask : key
  task automatic give_verdict();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    rst = 1'b1;
    key_seen = 1'b0;
    iso_bit_data = 1'b0;
    io_base = 16'h0100;
    rom_size_cfg = 3'h0;
    res_load_en = 1'b0;
    res_load_addr = 6'h00;
    res_load_data = 8'h00;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      r = lfsr();
      res_load_en <= 1'b1;
      res_load_addr <= 6'(i);
      res_load_data <= r;
      res_m.push_back(r);
    end
    @(posedge clk_sys);
    res_load_en <= 1'b0;
    #1 chk_st(st_q, pnp_regs_pkg::ST_WAIT_KEY);
    key();
    u_isa_host_model.reg_wr(8'h03, 8'h00);
    #1 chk_st(st_q, pnp_regs_pkg::ST_ISOLATION);
    r = lfsr() | 8'h80;
    u_isa_host_model.reg_wr(8'h00, r);
    #1 chk(rps_q, r);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      iso_bit_data <= seed[0];
      u_isa_host_model.reg_rd(8'h01, d);
      chk(d, {7'h00, iso_bit_data});
      r = lfsr();
    end
    csn_m = (lfsr() & 8'h7f) | 8'h01;
    u_isa_host_model.reg_wr(8'h06, csn_m);
    #1 chk({sav_q, csn_q}, {csn_m, csn_m});
    u_isa_host_model.reg_rd(8'h06, d);
    chk(d, csn_m);
    u_isa_host_model.reg_rd(8'hf5, d);
    chk(d, csn_m);
    for (int i = 0; i < 8; i++) begin
      u_isa_host_model.reg_wr(tbl[i][0], tbl[i][1]);
      u_isa_host_model.reg_rd(tbl[i][0], d);
      chk(d, tbl[i][2]);
    end
    chk(boot_rom_base_q, 16'h0dc0);
    chk(rng_q, 1'b1);
    @(posedge clk_sys);
    rom_size_cfg <= seed[2:0];
    repeat (2) @(posedge clk_sys);
    #1 chk(rsz_q, seed[2:0]);
    u_isa_host_model.rd(io_base + 16'h0007, d, v);
    chk(d, 8'h55);
    u_isa_host_model.reg_wr(8'h31, 8'h02);
    u_isa_host_model.rd(io_base + 16'h001f, d, v);
    chk(d, 8'haa);
    u_isa_host_model.activate();
    #1 chk(act_q, 1'b1);
    u_isa_host_model.rd(io_base, d, v);
    chk(v, 1'b0);
    // An active device must stay silent even with the check bit set
    u_isa_host_model.reg_wr(8'h31, 8'h02);
    u_isa_host_model.rd(io_base, d, v);
    chk(v, 1'b0);
    u_isa_host_model.reg_wr(8'h02, 8'h01);
    #1 chk(act_q, 1'b0);
    chk(boot_rom_base_q, 16'h0000);
    chk(drst_q, 1'b1);
    chk(csn_q, csn_m);
    u_isa_host_model.reg_rd(8'h02, d);
    chk(d, 8'h00);
    u_isa_host_model.reg_wr(8'h03, 8'h00);
    #1 chk_st(st_q, pnp_regs_pkg::ST_SLEEP);
    u_isa_host_model.reg_wr(8'h03, csn_m);
    #1 chk_st(st_q, pnp_regs_pkg::ST_CONFIG);
    for (int i = 0; i < 5; i++) begin
      u_isa_host_model.res_rd(d);
      chk(d, res_m.pop_front());
    end
    u_isa_host_model.reg_wr(8'h02, 8'h02);
    #1 chk_st(st_q, pnp_regs_pkg::ST_WAIT_KEY);
    chk(csn_q, csn_m);
    key();
    u_isa_host_model.reg_wr(8'h03, csn_m);
    u_isa_host_model.reg_wr(8'h02, 8'h04);
    #1 chk({sav_q, csn_q}, 16'h0000);
    give_verdict();
  end
endmodule : isa_pnp_card_registers_bench
